// [core/csda_consts.svh]
// Constants for the compare-skip and decimal-adjust execution block
`ifndef CSDA_CONSTS_SVH
`define CSDA_CONSTS_SVH

// ==========================================
// Opcode patterns: compares upper seven bits, decimal adjust whole word
`define CSDA_OPC_CPEQ 7'h31
`define CSDA_OPC_CPGT 7'h32
`define CSDA_OPC_CPLT 7'h30
`define CSDA_OPC_DAW 16'h0007

// ==========================================
// Q phases within an instruction cycle
`define CSDA_Q1 2'h0
`define CSDA_Q2 2'h1
`define CSDA_Q3 2'h2
`define CSDA_Q4 2'h3

// ==========================================
// Addressing
`define CSDA_ACCESS_SPLIT 8'h60
`define CSDA_ILO_LIMIT 8'h5F

// ==========================================
// Decimal adjust, reset and skip length values
`define CSDA_BCD_MAX 4'h9
`define CSDA_BCD_ADJ 5'h06
`define CSDA_W_RESET 8'h00
`define CSDA_SKIP_ONE 2'h1
`define CSDA_SKIP_TWO 2'h2

`endif

// [core/csda_exec.sv]
// Execution of the compare-skip and decimal-adjust instructions
//
// How it works
// - Equal compare decodes and skips when equal
// - Greater compare decoded with bank bit, address
// - Unsigned greater: skip when file strictly larger
// - Less compare decoded with bank bit, address
// - Unsigned less: skip when file strictly smaller
// - Taken skip discards next, runs a nop
// - Skipping two-word instruction takes three cycles
// - Decode Q1, read Q2, process Q3, no write
// - Bank bit 0 access bank, 1 uses bank_select_register
// - Extended set, bit 0, low address: indexed
// - Low nibble plus six when above nine or digit carry
// - High nibble plus digit carry, six more; only carry changes
// - Decimal adjust: one word, one cycle, writes working_register
`include "csda_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module csda_exec
   import csda_pkg::*;
#(
   parameter int BSR_W = 4
) (
   // Clock, reset, enable
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic clk_en,

   // Instruction from fetch
   input wire csda_instr_t instr,
   input wire logic next_two_word,
   output logic instr_ready,

   // Addressing context
   input wire logic [BSR_W-1:0] bank_select_register,
   input wire logic ext_set_en,
   input wire logic [BSR_W+7:0] index_base,

   // Data memory read port
   output logic file_rd,
   output logic [BSR_W+7:0] file_addr,
   input wire logic [7:0] file_rdata,

   // Working register and flags
   input wire logic w_load,
   input wire logic [7:0] w_load_data,
   output logic [7:0] working_register,
   input wire csda_flags_t flags_in,
   output logic carry_out,
   output logic carry_we,

   // Sequencing
   output logic [1:0] q_phase,
   output logic pc_step,
   output logic discard,
   output logic nop_cycle
);

   localparam int ADDR_W = BSR_W + 8;

   // ==========================================
   // Parameter check
   generate
      if (BSR_W < 1 || BSR_W > 8) begin : g_bad_bsr
         $error("csda_exec: BSR_W must be 1 to 8");
      end
   endgenerate

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_EXEC,
      ST_SKIP
   } csda_st_t;

   csda_st_t st_r;
   csda_st_t st_nxt;
   logic [1:0] q_r;
   csda_op_t op_r;
   csda_op_t op_nxt;
   logic [7:0] fdata_r;
   logic skip_r;
   logic [1:0] skip_left_r;
   logic [7:0] w_r;
   logic [7:0] daw_res_r;
   logic daw_carry_r;
   logic file_rd_r;
   logic [ADDR_W-1:0] file_addr_r;
   logic [ADDR_W-1:0] addr_nxt;
   logic pc_step_r;
   logic discard_r;
   logic carry_r;
   logic carry_we_r;
   logic take;
   logic [7:0] f_in;
   logic a_in;
   logic [4:0] lo_sum;
   logic [4:0] hi_sum;
   logic [4:0] lo_res;
   logic [4:0] hi_res;

   // ==========================================
   // Phase counter
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         q_r <= `CSDA_Q1;
      end else if (clk_en) begin
         q_r <= q_r + 2'h1;
      end
   end

   // ==========================================
   // Decode
   assign f_in = instr.word[7:0];
   assign a_in = instr.word[8];
   assign instr_ready = clk_en && st_r == ST_IDLE && q_r == `CSDA_Q1;
   assign take = instr_ready && instr.valid;

   always_comb begin
      op_nxt = CSDA_OP_NONE;
      if (instr.word == `CSDA_OPC_DAW) begin
         op_nxt = CSDA_OP_DAW;
      end else if (instr.word[15:9] == `CSDA_OPC_CPEQ) begin
         op_nxt = CSDA_OP_CPEQ;
      end else if (instr.word[15:9] == `CSDA_OPC_CPGT) begin
         op_nxt = CSDA_OP_CPGT;
      end else if (instr.word[15:9] == `CSDA_OPC_CPLT) begin
         op_nxt = CSDA_OP_CPLT;
      end
   end

   // Operand address from bank bit and mode
   always_comb begin
      if (a_in) begin
         addr_nxt = {bank_select_register, f_in};
      end else if (ext_set_en && f_in <= `CSDA_ILO_LIMIT) begin
         addr_nxt = ADDR_W'(index_base + {{BSR_W{1'b0}}, f_in});
      end else if (f_in < `CSDA_ACCESS_SPLIT) begin
         addr_nxt = {{BSR_W{1'b0}}, f_in};
      end else begin
         addr_nxt = {{BSR_W{1'b1}}, f_in};
      end
   end

   // ==========================================
   // Sequencer
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         ST_IDLE: begin
            if (take) begin
               st_nxt = ST_EXEC;
            end
         end
         ST_EXEC: begin
            if (q_r == `CSDA_Q4) begin
               st_nxt = skip_r ? ST_SKIP : ST_IDLE;
            end
         end
         ST_SKIP: begin
            if (q_r == `CSDA_Q4 && skip_left_r == `CSDA_SKIP_ONE) begin
               st_nxt = ST_IDLE;
            end
         end
         default: begin
            st_nxt = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         st_r <= ST_IDLE;
      end else if (clk_en) begin
         st_r <= st_nxt;
      end
   end

   // Operation held for the cycle
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         op_r <= CSDA_OP_NONE;
      end else if (take) begin
         op_r <= op_nxt;
      end
   end

   // ==========================================
   // Q2 file read; only compares read memory
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         file_rd_r <= 1'b0;
         file_addr_r <= '0;
      end else if (clk_en) begin
         file_rd_r <= take && op_nxt != CSDA_OP_NONE
            && op_nxt != CSDA_OP_DAW;
         if (take) begin
            file_addr_r <= addr_nxt;
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         fdata_r <= 8'h00;
      end else if (clk_en && file_rd_r) begin
         fdata_r <= file_rdata;
      end
   end

   // ==========================================
   // Q3 process: compare
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         skip_r <= 1'b0;
      end else if (clk_en) begin
         if (st_r == ST_EXEC && q_r == `CSDA_Q3) begin
            case (op_r)
               CSDA_OP_CPEQ: skip_r <= fdata_r == w_r;
               CSDA_OP_CPGT: skip_r <= fdata_r > w_r;
               CSDA_OP_CPLT: skip_r <= fdata_r < w_r;
               default: skip_r <= 1'b0;
            endcase
         end else if (q_r == `CSDA_Q4) begin
            skip_r <= 1'b0;
         end
      end
   end

   // Q3 process: decimal adjust
   always_comb begin
      lo_sum = {1'b0, w_r[3:0]};
      hi_sum = {1'b0, w_r[7:4]} + {4'h0, flags_in.digit_carry_flag};
      lo_res = lo_sum;
      if (lo_sum[3:0] > `CSDA_BCD_MAX || flags_in.digit_carry_flag) begin
         lo_res = lo_sum + `CSDA_BCD_ADJ;
      end
      hi_res = hi_sum;
      if (hi_sum > {1'b0, `CSDA_BCD_MAX} || flags_in.carry) begin
         hi_res = hi_sum + `CSDA_BCD_ADJ;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         daw_res_r <= 8'h00;
         daw_carry_r <= 1'b0;
      end else if (clk_en && st_r == ST_EXEC && q_r == `CSDA_Q3) begin
         daw_res_r <= {hi_res[3:0], lo_res[3:0]};
         daw_carry_r <= hi_res[4] | flags_in.carry;
      end
   end

   // ==========================================
   // Q4 write back: working register, carry only
   wire logic daw_wr = st_r == ST_EXEC && q_r == `CSDA_Q4
      && op_r == CSDA_OP_DAW;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         w_r <= `CSDA_W_RESET;
      end else if (clk_en) begin
         if (daw_wr) begin
            w_r <= daw_res_r;
         end else if (w_load) begin
            w_r <= w_load_data;
         end
      end
   end

   // Carry flag is the only status the block changes
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         carry_r <= 1'b0;
         carry_we_r <= 1'b0;
      end else if (clk_en) begin
         carry_we_r <= daw_wr;
         if (daw_wr) begin
            carry_r <= daw_carry_r;
         end
      end
   end

   // ==========================================
   // Skip length; latched in Q4 of the compare
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         skip_left_r <= 2'h0;
      end else if (clk_en && q_r == `CSDA_Q4) begin
         if (st_r == ST_EXEC && skip_r) begin
            skip_left_r <= next_two_word ? `CSDA_SKIP_TWO
               : `CSDA_SKIP_ONE;
         end else if (st_r == ST_SKIP) begin
            skip_left_r <= skip_left_r - 2'h1;
         end
      end
   end

   // One word per cycle keeps the counter in step with skips
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pc_step_r <= 1'b0;
         discard_r <= 1'b0;
      end else if (clk_en) begin
         pc_step_r <= q_r == `CSDA_Q4
            && (st_r == ST_EXEC || st_r == ST_SKIP);
         discard_r <= q_r == `CSDA_Q4 && st_r == ST_EXEC
            && skip_r;
      end
   end

   // ==========================================
   // Outputs
   assign q_phase = q_r;
   assign file_rd = file_rd_r;
   assign file_addr = file_addr_r;
   assign working_register = w_r;
   assign carry_out = carry_r;
   assign carry_we = carry_we_r;
   assign pc_step = pc_step_r;
   assign discard = discard_r;
   assign nop_cycle = st_r == ST_SKIP;

endmodule // csda_exec

`default_nettype wire

// [core/csda_pkg.sv]
// Types for the compare-skip and decimal-adjust execution block
package csda_pkg;

   // ==========================================
   // Decoded operation
   typedef enum logic [2:0] {
      CSDA_OP_NONE,
      CSDA_OP_CPEQ,
      CSDA_OP_CPGT,
      CSDA_OP_CPLT,
      CSDA_OP_DAW
   } csda_op_t;

   // ==========================================
   // Status flags seen by the block; it changes only carry
   typedef struct packed {
      logic carry;
      logic digit_carry_flag;
   } csda_flags_t;

   // ==========================================
   // Instruction word offered at Q1
   typedef struct packed {
      logic valid;
      logic [15:0] word;
   } csda_instr_t;

endpackage

// [tb/csda_exec_props.sv]
// Checker for the compare-skip and decimal-adjust block
`timescale 1ns/100ps
`default_nettype none
module csda_exec_chk
   import csda_pkg::*;
#(parameter int BSR_W = 4) (
   // Clock, reset, enable
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic clk_en,
   // Observed ports
   input wire csda_instr_t instr,
   input wire logic instr_ready,
   input wire logic [BSR_W-1:0] bank_select_register,
   input wire logic file_rd,
   input wire logic [BSR_W+7:0] file_addr,
   input wire logic carry_we,
   input wire logic [1:0] q_phase,
   input wire logic pc_step,
   input wire logic discard,
   input wire logic nop_cycle
);
   // ==========
   // Helpers
   logic tk, cmp, decimal_adjust_op;
   assign tk = instr_ready && instr.valid;
   assign cmp = tk && instr.word[15:11] == 5'h0C && instr.word[10:9] != 2'h3;
   assign decimal_adjust_op = tk && instr.word == 16'h0007;
   // Frozen cycles would stretch every count
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst || !clk_en);
   // ==========
   // Properties
   chk_rd_after: assert property (cmp |=> file_rd)
      else $error("no read after compare");
   chk_rd_q2: assert property (file_rd |-> q_phase == 2'h1)
      else $error("read outside second phase");
   chk_rd_pulse: assert property (file_rd |=> !file_rd)
      else $error("read longer than one cycle");
   chk_adj_nord: assert property (decimal_adjust_op |=> (!file_rd) [*3])
      else $error("file read in decimal adjust");
   chk_adj_done: assert property (decimal_adjust_op |-> ##4 carry_we && pc_step)
      else $error("decimal adjust not one cycle");
   chk_cmp_nocy: assert property (cmp |-> ##4 pc_step && !carry_we)
      else $error("compare end wrong");
   chk_skip_nop: assert property (discard |-> nop_cycle && pc_step)
      else $error("discard without nop step");
   chk_nop_busy: assert property (
      nop_cycle |-> !instr_ready && !file_rd)
      else $error("activity in nop cycle");
   chk_bank_addr: assert property (cmp && instr.word[8] |=>
      file_addr == {$past(bank_select_register), $past(instr.word[7:0])})
      else $error("banked address wrong");
   cover property (discard);
   cover property (decimal_adjust_op ##4 carry_we);
   cover property (nop_cycle [*8]);
endmodule // csda_exec_chk
bind csda_exec csda_exec_chk #(.BSR_W(BSR_W)) u_chk (.core_clk, .nrst,
   .clk_en, .instr, .instr_ready, .bank_select_register, .file_rd,
   .file_addr, .carry_we, .q_phase, .pc_step, .discard, .nop_cycle);
`default_nettype wire

// [tb/csda_exec_tb_top.sv]
// Self-checking bench for the compare-skip and decimal-adjust block
`timescale 1ns/100ps
`default_nettype none
module csda_exec_tb_top
   import csda_pkg::*;
;
   typedef struct packed {
      logic [15:0] op;
      logic [7:0] w, rd;
      logic [1:0] fl;
      logic ext, two;
      logic [11:0] ea;
      logic [3:0] cyc;
      logic [7:0] ew;
      logic ec, rdn;
   } csda_row_t;
   logic core_clk, nrst, clk_en, next_two_word, instr_ready, ext_set_en;
   logic file_rd, w_load, carry_out, carry_we, pc_step, discard, nop_cycle;
   csda_instr_t instr;
   csda_flags_t flags_in;
   logic [11:0] file_addr, index_base;
   logic [3:0] bank_select_register;
   logic [7:0] file_rdata, w_load_data, working_register;
   logic [1:0] q_phase;
   int errors, cmp_count;
   csda_row_t rows [12];
   csda_exec #(.BSR_W(4)) DUT (.core_clk, .nrst, .clk_en, .instr,
      .next_two_word, .instr_ready, .bank_select_register,
      .ext_set_en, .index_base, .file_rd, .file_addr,
      .file_rdata, .w_load, .w_load_data, .working_register, .flags_in,
      .carry_out, .carry_we, .q_phase, .pc_step, .discard, .nop_cycle);
   // ==========
   // Clock and watchdog
   initial begin
      core_clk = 0;
      forever #10 core_clk = ~core_clk;
   end
   initial begin
      #50000;
      errors++;
      complete_run();
   end
   // ==========
   // Tasks
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      cmp_count++;
      if (s !== e) begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic complete_run();
      $display("errors %0d comparisons %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic do_reset();
      nrst <= 0;
      repeat (4) @(negedge core_clk);
      chk(16'(working_register), 16'h0000);
      chk(16'({nop_cycle, discard, pc_step, file_rd, carry_we, q_phase}),
         16'h0000);
      nrst <= 1;
   endtask
   task automatic run(input csda_row_t r, input int st);
      int n, pcs, nops, rds, cwe, dsc;
      logic c;
      pcs = 0;
      nops = 0;
      rds = 0;
      cwe = 0;
      dsc = 0;
      c = 0;
      w_load <= 1; w_load_data <= r.w; flags_in <= r.fl;
      ext_set_en <= r.ext; file_rdata <= r.rd; next_two_word <= r.two;
      @(negedge core_clk);
      w_load <= 0;
      @(negedge core_clk);
      for (n = 0; n < 8 && instr_ready !== 1'b1; n++) @(negedge core_clk);
      instr <= {1'b1, r.op};
      @(negedge core_clk);
      instr <= '0;
      // Stall mid-instruction: nothing may advance
      if (st > 0) begin
         clk_en <= 0;
         repeat (st) @(negedge core_clk);
         clk_en <= 1;
      end
      for (n = 1; n < 15; n++) begin
         pcs += pc_step;
         nops += nop_cycle;
         rds += file_rd;
         cwe += carry_we;
         dsc += discard;
         if (file_rd === 1'b1) chk(16'(file_addr), 16'(r.ea));
         if (carry_we === 1'b1) c = carry_out;
         if (instr_ready === 1'b1) break;
         @(negedge core_clk);
      end
      chk(16'(n), 16'(r.cyc));
      chk(16'(pcs), 16'(r.cyc >> 2));
      chk(16'(nops), 16'(r.cyc - 4'h4));
      chk(16'(rds), 16'(r.rdn));
      chk(16'(cwe), 16'(!r.rdn));
      chk(16'(dsc), 16'(r.cyc > 4'h4));
      chk(16'(working_register), 16'(r.ew));
      if (!r.rdn) chk(16'(c), 16'(r.ec));
   endtask
   // ==========
   // Main sequence
   initial begin
      nrst = 0;
      clk_en = 1;
      instr = '0;
      next_two_word = 0;
      ext_set_en = 0;
      file_rdata = 8'h00;
      w_load = 0;
      w_load_data = 8'h00;
      flags_in = '0;
      bank_select_register = 4'h5;
      index_base = 12'h300;
      // Unsigned edge cases 0x80 against 0x7F catch a signed compare
      rows = '{
      '{16'h6220,8'h44,8'h44,2'h0,1'h0,1'h0,12'h020,4'h8,8'h44,1'h0,1'h1},
      '{16'h6380,8'h44,8'h45,2'h0,1'h0,1'h0,12'h580,4'h4,8'h44,1'h0,1'h1},
      '{16'h6470,8'h7F,8'h80,2'h0,1'h0,1'h0,12'hF70,4'h8,8'h7F,1'h0,1'h1},
      '{16'h645F,8'h44,8'h44,2'h0,1'h1,1'h0,12'h35F,4'h4,8'h44,1'h0,1'h1},
      '{16'h6060,8'h80,8'h7F,2'h0,1'h1,1'h1,12'hF60,4'hC,8'h80,1'h0,1'h1},
      '{16'h6101,8'h80,8'h81,2'h0,1'h0,1'h1,12'h501,4'h4,8'h80,1'h0,1'h1},
      '{16'h0007,8'hA5,8'h00,2'h0,1'h0,1'h0,12'h000,4'h4,8'h05,1'h1,1'h0},
      '{16'h0007,8'h45,8'h00,2'h2,1'h0,1'h0,12'h000,4'h4,8'hA5,1'h1,1'h0},
      '{16'h0007,8'h39,8'h00,2'h0,1'h0,1'h0,12'h000,4'h4,8'h39,1'h0,1'h0},
      '{16'h0007,8'h0B,8'h00,2'h0,1'h0,1'h0,12'h000,4'h4,8'h01,1'h0,1'h0},
      '{16'h0007,8'h42,8'h00,2'h1,1'h0,1'h0,12'h000,4'h4,8'h58,1'h0,1'h0},
      '{16'h0007,8'h92,8'h00,2'h1,1'h0,1'h0,12'h000,4'h4,8'h08,1'h1,1'h0}};
      do_reset();
      foreach (rows[i]) run(rows[i], (i == 2 || i == 7) ? 3 : 0);
      // Reset in mid-skip: no skip or nop may survive it
      w_load <= 1'h1;
      w_load_data <= 8'h44;
      file_rdata <= 8'h44;
      next_two_word <= 1'h1;
      @(negedge core_clk);
      w_load <= 1'h0;
      for (int k = 0; k < 8 && instr_ready !== 1'b1; k++)
         @(negedge core_clk);
      instr <= {1'h1, 16'h6220};
      @(negedge core_clk);
      instr <= '0;
      repeat (5) @(negedge core_clk);
      chk(16'({nop_cycle, discard}), 16'h0002);
      do_reset();
      // New bank and index base after reset
      bank_select_register <= 4'hA;
      index_base <= 12'h7C0;
      run('{16'h6380,8'h44,8'h45,2'h0,1'h0,1'h0,12'hA80,4'h4,8'h44,
         1'h0,1'h1}, 0);
      run('{16'h6410,8'h10,8'hFF,2'h0,1'h1,1'h0,12'h7D0,4'h8,8'h10,
         1'h0,1'h1}, 0);
      complete_run();
   end
endmodule // csda_exec_tb_top
`default_nettype wire
